/* uart_aux_pkg.sv */
package uart_aux_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 2;
  localparam int NIB_W  = 4;
  localparam int CORE_W = 10;

  // Byte addresses of the register words.
  localparam logic [7:0] OFS_SCRATCH   = 8'h00;
  localparam logic [7:0] OFS_FLOW      = 8'h04;
  localparam logic [7:0] OFS_TRIGGER   = 8'h08;
  localparam logic [7:0] OFS_TX_SPACE  = 8'h0c;
  localparam logic [7:0] OFS_RX_FILL   = 8'h10;
  localparam logic [7:0] OFS_PIN_DIR   = 8'h14;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h18;
  localparam logic [7:0] OFS_PIN_IRQEN = 8'h1c;
  localparam logic [7:0] OFS_PIN_CTRL  = 8'h20;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h24;
  localparam logic [7:0] OFS_MODEM_ST  = 8'h28;

  localparam logic [7:0]        RESET_BYTE = 8'h00;
  localparam logic [CORE_W-1:0] RESET_CORE = 10'h000;
  localparam logic [6:0]        RESET_CNT  = 7'h00;
  localparam logic [5:0]        RESET_LVL  = 6'h00;
  localparam logic [3:0]        ZERO_NIB   = 4'h0;

  // Field positions inside bytes.
  localparam int NIB_LO = 0;
  localparam int NIB_HI = 4;
  localparam int PC_LATCH   = 0;
  localparam int PC_MODEM_A = 1;
  localparam int PC_MODEM_B = 2;
  localparam int PC_SOFT_RESET_BIT  = 3;
  localparam int PC_KEEP_W  = 3;

  // Core control word: enable bits, DTR bits and FIFO trigger fields borrowed from the UART core registers.
  localparam int CC_EFR_ENH  = 0;
  localparam int CC_MCR_TCR  = 1;
  localparam int CC_DTR_BASE = 2;
  localparam int CC_MSI_BASE = 4;
  localparam int CC_FCR_RX   = 6;
  localparam int CC_FCR_TX   = 8;

  // Modem line positions inside a pin nibble.
  localparam int NIB_DSR = 0;
  localparam int NIB_DTR = 1;
  localparam int NIB_CD  = 2;
  localparam int NIB_RI  = 3;
  localparam logic [3:0] DTR_MASK  = 4'h2;
  localparam logic [3:0] FULL_NIB  = 4'hf;
  localparam logic [1:0] STEP_PAD  = 2'b00;

  // Fallback levels chosen by the two-bit FIFO control trigger fields.
  localparam logic [5:0] FCR_RX_LEVELS [4] = '{6'h08, 6'h10, 6'h20, 6'h38};
  localparam logic [5:0] FCR_TX_LEVELS [4] = '{6'h08, 6'h10, 6'h20, 6'h38};
  localparam logic [5:0] FLOW_RESUME_FB = 6'h00;

endpackage

/* gpio_change_if.sv */
`timescale 1ns/10ps
interface gpio_change_if;
  logic [7:0] pins;
  logic [7:0] watch;
  logic       latch_en;
  logic       level_read;
  logic [7:0] level_view;
  logic [7:0] pend;
  modport ctrl (output pins, watch, latch_en, level_read, input level_view, pend);
  modport unit (input pins, watch, latch_en, level_read, output level_view, pend);
endinterface

/* level_pick.sv */
`timescale 1ns/10ps
module level_pick (
  input  wire logic [3:0] nib,      // Programmed level divided by four.
  input  wire logic [5:0] fallback, // Level chosen by the FIFO control field.
  input  wire logic       use_fb,   // High when the programmed value is ignored.
  output logic      [5:0] level     // Effective level in characters.
);
  assign level = use_fb ? fallback : {nib, uart_aux_pkg::STEP_PAD};
endmodule

/* gpio_change_unit.sv */
`timescale 1ns/10ps
module gpio_change_unit (
  input  wire logic     clk, // Core clock.
  input  wire logic     rst, // Synchronous reset, active high.
  gpio_change_if.unit   io   // Pin levels in, change flags out.
);
  logic primed_q;

  // The reference is loaded once after reset so a pin held high is not seen as a change.
  always_ff @(posedge clk) begin
    if (rst) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      logic ref_q;
      logic flag_q;
      logic cap_q;
      always_ff @(posedge clk) begin
        if (rst) begin
          ref_q  <= 1'b0;
          flag_q <= 1'b0;
          cap_q  <= 1'b0;
        end else if (!primed_q || !io.watch[i]) begin
          ref_q  <= io.pins[i];
          flag_q <= 1'b0;
          cap_q  <= io.pins[i];
        end else if (io.level_read) begin
          ref_q  <= io.pins[i];
          flag_q <= 1'b0;
        end else if (io.latch_en && !flag_q && (io.pins[i] != ref_q)) begin
          flag_q <= 1'b1;
          cap_q  <= io.pins[i];
        end
      end
      assign io.pend[i] = io.latch_en ? flag_q : (io.pins[i] != ref_q);
      assign io.level_view[i] = (io.latch_en && flag_q) ? cap_q : io.pins[i];

      AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
        io.latch_en && flag_q && !io.level_read && io.watch[i] && $stable(io.latch_en)
        |=> flag_q && io.level_view[i] == $past(cap_q))
        else $error("latched pin change lost before read");
      AST_NOLATCH_RETURN: assert property (@(posedge clk) disable iff (rst)
        io.level_read && !io.latch_en ##1 $stable(io.pins[i]) |-> !io.pend[i])
        else $error("unlatched change still pending after level read");
    end
  endgenerate
endmodule

/* uart_aux_regs.sv */
`timescale 1ns/10ps
module uart_aux_regs (
  input  wire logic        REF_CLK,       // Core clock, 25 MHz.
  input  wire logic        RST,           // Synchronous reset, active high.
  input  wire logic        PSEL,          // APB select.
  input  wire logic        PENABLE,       // APB access phase.
  input  wire logic        PWRITE,        // APB direction, high for write.
  input  wire logic [7:0]  PADDR,         // APB byte address.
  input  wire logic [31:0] PWDATA,        // APB write data.
  output logic      [31:0] PRDATA,        // APB read data.
  output logic             PREADY,        // APB ready.
  output logic             PSLVERR,       // APB error on unmapped address.
  input  wire logic [6:0]  TX_SPACE,      // Free places in the TX FIFO.
  input  wire logic [6:0]  RX_FILL,       // Characters held in the RX FIFO.
  input  wire logic [7:0]  GPIO_IN,       // Pin levels, asynchronous.
  output logic      [7:0]  GPIO_OUT,      // Pin drive values.
  output logic      [7:0]  GPIO_OE,       // Pin output enables.
  output logic             GPIO_IRQ,      // Pin change interrupt.
  output logic      [1:0]  MODEM_IRQ,     // Modem change interrupt, bit 1 channel A.
  output logic      [5:0]  RX_TRIG_LEVEL, // RX interrupt level in characters.
  output logic      [5:0]  TX_TRIG_LEVEL, // TX interrupt level in spaces.
  output logic      [5:0]  FLOW_HALT,     // RX fill that halts the far transmitter.
  output logic      [5:0]  FLOW_RESUME,   // RX fill that lets it resume.
  output logic             SOFT_RESET     // One-cycle reset pulse for the rest of the chip.
);
  localparam int NC = uart_aux_pkg::NUM_CH;
  localparam int NW = uart_aux_pkg::NIB_W;

  logic [7:0]  scratch_q;
  logic [7:0]  flow_q;
  logic [7:0]  trig_q;
  logic [7:0]  dir_q;
  logic [7:0]  out_q;
  logic [7:0]  ien_q;
  logic [2:0]  pc_q;
  logic [uart_aux_pkg::CORE_W-1:0] core_q;
  logic        srst_q;
  logic        rst_all;
  logic [7:0]  pin_m_q;
  logic [7:0]  pin_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_data;
  logic        addr_hit;
  logic        setup;
  logic        fire;
  logic        wr_fire;
  logic        rd_take;
  logic        unlock;
  logic [NC-1:0] mode;
  wire  [7:0]  oe_d;
  wire  [7:0]  out_d;
  wire  [7:0]  watch_d;
  wire  [7:0]  gp_mask;
  wire  [7:0]  ms_view;
  wire  [NC-1:0] msirq_d;
  logic [2:0]  mlvl_q [NC];
  logic        mdelta_q [NC];
  logic [5:0]  rx_lvl;
  logic [5:0]  tx_lvl;
  logic [5:0]  halt_lvl;
  logic [5:0]  resume_lvl;
  logic [7:0]  gpio_out_q;
  logic [7:0]  gpio_oe_q;
  logic        gpio_irq_q;
  logic [1:0]  modem_irq_q;
  logic [5:0]  rx_trig_q;
  logic [5:0]  tx_trig_q;
  logic [5:0]  halt_q;
  logic [5:0]  resume_q;

  gpio_change_if gif ();

  // The soft reset clears every register here except the pin synchroniser and the bus handshake,
  // so the write that fired it still completes cleanly.
  assign rst_all = RST || srst_q;

  assign setup   = PSEL && !PENABLE && !pready_q;
  assign fire    = PSEL && PENABLE && pready_q;
  assign wr_fire = fire && PWRITE;
  assign rd_take = setup && !PWRITE;
  assign unlock  = core_q[uart_aux_pkg::CC_EFR_ENH] && core_q[uart_aux_pkg::CC_MCR_TCR];
  assign mode    = {pc_q[uart_aux_pkg::PC_MODEM_A], pc_q[uart_aux_pkg::PC_MODEM_B]};

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pin_m_q <= uart_aux_pkg::RESET_BYTE;
      pin_q   <= uart_aux_pkg::RESET_BYTE;
    end else begin
      pin_m_q <= GPIO_IN;
      pin_q   <= pin_m_q;
    end
  end

  // Zero wait states: ready rises in the access phase right after setup.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !addr_hit;
      if (rd_take) begin
        prdata_q <= rd_data;
      end
    end
  end

  always_comb begin
    rd_data  = 32'h0000_0000;
    addr_hit = 1'b1;
    if (PADDR == uart_aux_pkg::OFS_SCRATCH) begin
      rd_data[7:0] = scratch_q;
    end else if (PADDR == uart_aux_pkg::OFS_FLOW) begin
      rd_data[7:0] = flow_q;
    end else if (PADDR == uart_aux_pkg::OFS_TRIGGER) begin
      rd_data[7:0] = trig_q;
    end else if (PADDR == uart_aux_pkg::OFS_TX_SPACE) begin
      rd_data[6:0] = TX_SPACE;
    end else if (PADDR == uart_aux_pkg::OFS_RX_FILL) begin
      rd_data[6:0] = RX_FILL;
    end else if (PADDR == uart_aux_pkg::OFS_PIN_DIR) begin
      rd_data[7:0] = dir_q;
    end else if (PADDR == uart_aux_pkg::OFS_PIN_LEVEL) begin
      rd_data[7:0] = gif.level_view & gp_mask;
    end else if (PADDR == uart_aux_pkg::OFS_PIN_IRQEN) begin
      rd_data[7:0] = ien_q;
    end else if (PADDR == uart_aux_pkg::OFS_PIN_CTRL) begin
      rd_data[2:0] = pc_q;
    end else if (PADDR == uart_aux_pkg::OFS_CORE_CTRL) begin
      rd_data[uart_aux_pkg::CORE_W-1:0] = core_q;
    end else if (PADDR == uart_aux_pkg::OFS_MODEM_ST) begin
      rd_data[7:0] = ms_view;
    end else begin
      addr_hit = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (rst_all) begin
      scratch_q <= uart_aux_pkg::RESET_BYTE;
    end else if (wr_fire && PADDR == uart_aux_pkg::OFS_SCRATCH) begin
      scratch_q <= PWDATA[7:0];
    end
  end

  // Both thresholds stay frozen unless the core has opened them for writing.
  always_ff @(posedge REF_CLK) begin
    if (rst_all) begin
      flow_q <= uart_aux_pkg::RESET_BYTE;
      trig_q <= uart_aux_pkg::RESET_BYTE;
    end else if (wr_fire && unlock) begin
      if (PADDR == uart_aux_pkg::OFS_FLOW) begin
        flow_q <= PWDATA[7:0];
      end
      if (PADDR == uart_aux_pkg::OFS_TRIGGER) begin
        trig_q <= PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (rst_all) begin
      dir_q <= uart_aux_pkg::RESET_BYTE;
      out_q <= uart_aux_pkg::RESET_BYTE;
      ien_q <= uart_aux_pkg::RESET_BYTE;
    end else if (wr_fire) begin
      if (PADDR == uart_aux_pkg::OFS_PIN_DIR) begin
        dir_q <= PWDATA[7:0];
      end
      if (PADDR == uart_aux_pkg::OFS_PIN_LEVEL) begin
        out_q <= PWDATA[7:0];
      end
      if (PADDR == uart_aux_pkg::OFS_PIN_IRQEN) begin
        ien_q <= PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (rst_all) begin
      pc_q   <= uart_aux_pkg::RESET_BYTE[2:0];
      core_q <= uart_aux_pkg::RESET_CORE;
    end else if (wr_fire) begin
      if (PADDR == uart_aux_pkg::OFS_PIN_CTRL) begin
        pc_q <= PWDATA[uart_aux_pkg::PC_KEEP_W-1:0];
      end
      if (PADDR == uart_aux_pkg::OFS_CORE_CTRL) begin
        core_q <= PWDATA[uart_aux_pkg::CORE_W-1:0];
      end
    end
  end

  // The pulse lasts one cycle because it resets itself through rst_all.
  always_ff @(posedge REF_CLK) begin
    if (rst_all) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_fire && PADDR == uart_aux_pkg::OFS_PIN_CTRL
                && PWDATA[uart_aux_pkg::PC_SOFT_RESET_BIT];
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NC; ch++) begin : g_modem
      localparam int B = ch * NW;
      logic [2:0] now;
      logic       dtr;
      assign dtr = core_q[uart_aux_pkg::CC_DTR_BASE + ch];
      assign now = mode[ch] ? ~{pin_q[B + uart_aux_pkg::NIB_CD],
                                pin_q[B + uart_aux_pkg::NIB_RI],
                                pin_q[B + uart_aux_pkg::NIB_DSR]} : 3'b000;
      assign oe_d[B +: NW]    = mode[ch] ? uart_aux_pkg::DTR_MASK : dir_q[B +: NW];
      assign out_d[B +: NW]   = mode[ch] ? (dtr ? uart_aux_pkg::ZERO_NIB : uart_aux_pkg::DTR_MASK)
                                         : out_q[B +: NW];
      assign watch_d[B +: NW] = mode[ch] ? uart_aux_pkg::ZERO_NIB : ~dir_q[B +: NW];
      assign gp_mask[B +: NW] = mode[ch] ? uart_aux_pkg::ZERO_NIB : uart_aux_pkg::FULL_NIB;
      assign ms_view[B +: NW] = {mdelta_q[ch], mlvl_q[ch]};
      assign msirq_d[ch] = mdelta_q[ch] && core_q[uart_aux_pkg::CC_MSI_BASE + ch];
      // A change seen in the same cycle as a status read is kept, not cleared.
      always_ff @(posedge REF_CLK) begin
        if (rst_all) begin
          mlvl_q[ch]   <= 3'b000;
          mdelta_q[ch] <= 1'b0;
        end else begin
          mlvl_q[ch] <= now;
          if (mode[ch] && now != mlvl_q[ch]) begin
            mdelta_q[ch] <= 1'b1;
          end else if (rd_take && PADDR == uart_aux_pkg::OFS_MODEM_ST) begin
            mdelta_q[ch] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign gif.pins       = pin_q;
  assign gif.watch      = watch_d;
  assign gif.latch_en   = pc_q[uart_aux_pkg::PC_LATCH];
  assign gif.level_read = rd_take && PADDR == uart_aux_pkg::OFS_PIN_LEVEL;

  gpio_change_unit u_change (
    .clk (REF_CLK),
    .rst (rst_all),
    .io  (gif.unit)
  );

  // The FIFO control fallback applies per FIFO for triggers, but only for the
  // whole flow byte at once; a half-programmed flow byte is taken literally.
  level_pick u_rx_pick (
    .nib      (trig_q[uart_aux_pkg::NIB_HI +: NW]),
    .fallback (uart_aux_pkg::FCR_RX_LEVELS[core_q[uart_aux_pkg::CC_FCR_RX +: 2]]),
    .use_fb   (trig_q[uart_aux_pkg::NIB_HI +: NW] == uart_aux_pkg::ZERO_NIB),
    .level    (rx_lvl)
  );
  level_pick u_tx_pick (
    .nib      (trig_q[uart_aux_pkg::NIB_LO +: NW]),
    .fallback (uart_aux_pkg::FCR_TX_LEVELS[core_q[uart_aux_pkg::CC_FCR_TX +: 2]]),
    .use_fb   (trig_q[uart_aux_pkg::NIB_LO +: NW] == uart_aux_pkg::ZERO_NIB),
    .level    (tx_lvl)
  );
  level_pick u_halt_pick (
    .nib      (flow_q[uart_aux_pkg::NIB_LO +: NW]),
    .fallback (uart_aux_pkg::FCR_RX_LEVELS[core_q[uart_aux_pkg::CC_FCR_RX +: 2]]),
    .use_fb   (flow_q == uart_aux_pkg::RESET_BYTE),
    .level    (halt_lvl)
  );
  level_pick u_resume_pick (
    .nib      (flow_q[uart_aux_pkg::NIB_HI +: NW]),
    .fallback (uart_aux_pkg::FLOW_RESUME_FB),
    .use_fb   (flow_q == uart_aux_pkg::RESET_BYTE),
    .level    (resume_lvl)
  );

  always_ff @(posedge REF_CLK) begin
    if (rst_all) begin
      gpio_out_q  <= uart_aux_pkg::RESET_BYTE;
      gpio_oe_q   <= uart_aux_pkg::RESET_BYTE;
      gpio_irq_q  <= 1'b0;
      modem_irq_q <= 2'b00;
    end else begin
      gpio_out_q  <= out_d;
      gpio_oe_q   <= oe_d;
      gpio_irq_q  <= |(gif.pend & watch_d & ien_q);
      modem_irq_q <= msirq_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (rst_all) begin
      rx_trig_q <= uart_aux_pkg::RESET_LVL;
      tx_trig_q <= uart_aux_pkg::RESET_LVL;
      halt_q    <= uart_aux_pkg::RESET_LVL;
      resume_q  <= uart_aux_pkg::RESET_LVL;
    end else begin
      rx_trig_q <= rx_lvl;
      tx_trig_q <= tx_lvl;
      halt_q    <= halt_lvl;
      resume_q  <= resume_lvl;
    end
  end

  assign PRDATA        = prdata_q;
  assign PREADY        = pready_q;
  assign PSLVERR       = pslverr_q;
  assign GPIO_OUT      = gpio_out_q;
  assign GPIO_OE       = gpio_oe_q;
  assign GPIO_IRQ      = gpio_irq_q;
  assign MODEM_IRQ     = modem_irq_q;
  assign RX_TRIG_LEVEL = rx_trig_q;
  assign TX_TRIG_LEVEL = tx_trig_q;
  assign FLOW_HALT     = halt_q;
  assign FLOW_RESUME   = resume_q;
  assign SOFT_RESET    = srst_q;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  AST_SCRATCH_READ: assert property (
    rd_take && PADDR == uart_aux_pkg::OFS_SCRATCH |=> PRDATA == {24'h000000, $past(scratch_q)})
    else $error("scratch read returned wrong value");
  AST_FLOW_LOCKED: assert property (
    wr_fire && !unlock && !srst_q |=> $stable(flow_q) && $stable(trig_q))
    else $error("locked threshold write took effect");
  AST_TRIG_SCALE: assert property (
    trig_q[7:4] != 4'h0 && !srst_q |=> RX_TRIG_LEVEL == {$past(trig_q[7:4]), 2'b00})
    else $error("RX trigger level not four times the nibble");
  AST_TRIG_FALLBACK: assert property (
    trig_q[3:0] == 4'h0 && !srst_q
    |=> TX_TRIG_LEVEL == uart_aux_pkg::FCR_TX_LEVELS[$past(core_q[9:8])])
    else $error("zero TX nibble did not fall back");
  AST_FLOW_FALLBACK: assert property (
    flow_q == 8'h00 && !srst_q
    |=> FLOW_HALT == uart_aux_pkg::FCR_RX_LEVELS[$past(core_q[7:6])])
    else $error("cleared flow byte did not use control levels");
  AST_TX_COUNT_READ: assert property (
    rd_take && PADDR == uart_aux_pkg::OFS_TX_SPACE |=> PRDATA == {25'h0, $past(TX_SPACE)})
    else $error("TX space read wrong or bit seven set");
  AST_SOFT_RESET_BIT_PULSE: assert property (
    wr_fire && PADDR == uart_aux_pkg::OFS_PIN_CTRL && PWDATA[3]
    |=> SOFT_RESET ##1 !SOFT_RESET && scratch_q == 8'h00 && pc_q == 3'b000)
    else $error("soft reset did not pulse and clear");
  AST_MODEM_OE: assert property (
    mode[0] && !srst_q |=> GPIO_OE[3:0] == 4'h2 && GPIO_OUT[1] == !$past(core_q[2]))
    else $error("modem nibble B drive wrong");
  AST_GPIO_OE: assert property (
    !mode[1] && !srst_q |=> GPIO_OE[7:4] == $past(dir_q[7:4]))
    else $error("pin direction not applied");
  AST_MODEM_INV: assert property (
    mode[1] && $stable(mode) |=> mlvl_q[1][0] == !$past(pin_q[4]))
    else $error("modem level not inverted pin");
  AST_GPMODE_NO_STATUS: assert property (
    !mode[0] && !mdelta_q[0] |=> !mdelta_q[0] && mlvl_q[0] == 3'b000)
    else $error("general pins updated modem status");
  AST_MODEM_IRQ_GATE: assert property (
    !core_q[4] && !srst_q |=> !MODEM_IRQ[0])
    else $error("modem interrupt without enable");
  AST_PIN_IRQ_GATE: assert property (
    (gif.pend & watch_d & ien_q) == 8'h00 && !srst_q |=> !GPIO_IRQ)
    else $error("pin interrupt without enabled change");
  AST_RESET_ZERO: assert property (disable iff (1'b0)
    RST |=> scratch_q == 8'h00 && dir_q == 8'h00 && GPIO_OE == 8'h00 && flow_q == 8'h00)
    else $error("registers not zero after reset");

  COV_SCRATCH_WRITE: cover property (wr_fire && PADDR == uart_aux_pkg::OFS_SCRATCH);
  COV_MODEM_IRQ: cover property (MODEM_IRQ[1]);
  COV_LATCHED_IRQ: cover property (gif.latch_en && GPIO_IRQ);
  COV_SOFT_RESET: cover property (SOFT_RESET);
endmodule

/* apb_host.sv */
`timescale 1ns/10ps
module apb_host (
  input  wire logic        clk,     // Bus clock.
  output logic             psel,    // Select.
  output logic             penable, // Access phase.
  output logic             pwrite,  // High for write.
  output logic [7:0]       paddr,   // Byte address.
  output logic [31:0]      pwdata,  // Write data.
  input  wire logic [31:0] prdata,  // Read data.
  input  wire logic        pready,  // Slave ready.
  input  wire logic        pslverr  // Slave error.
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // The request is held until pready is sampled high, so a slow slave is served too.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

/* uart_bridge_aux_registers_test.sv */
`timescale 1ns/10ps
module uart_bridge_aux_registers_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq, srst;
  logic [7:0] paddr, oe, out, gin;
  logic [7:0] ext = 8'h00;
  logic [31:0] pwdata, prdata;
  logic [6:0] tx = 7'h00;
  logic [6:0] rx = 7'h00;
  logic [1:0] mirq;
  logic [5:0] rxl, txl, fh, fr;
  logic [31:0] mdl [logic [7:0]];
  int mismatches = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  // Pins driven by the block win over the external drivers.
  assign gin = (oe & out) | (~oe & ext);
  apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  uart_aux_regs u_dut (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TX_SPACE(tx), .RX_FILL(rx), .GPIO_IN(gin), .GPIO_OUT(out),
    .GPIO_OE(oe), .GPIO_IRQ(irq), .MODEM_IRQ(mirq), .RX_TRIG_LEVEL(rxl),
    .TX_TRIG_LEVEL(txl), .FLOW_HALT(fh), .FLOW_RESUME(fr), .SOFT_RESET(srst));
  task automatic results();
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] r;
    logic e;
    u_host.xfer(1'b0, a, 32'h0, r, e);
    chk("rd_err", {31'h0, !mdl.exists(a)}, {31'h0, e});
    chk("rd_data", mdl.exists(a) ? mdl[a] : 32'h0, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_host.xfer(1'b1, a, d, r, e);
    chk("wr_err", 32'h0, {31'h0, e});
    case (a)
      uart_aux_pkg::OFS_FLOW, uart_aux_pkg::OFS_TRIGGER:
        if (mdl[uart_aux_pkg::OFS_CORE_CTRL][1:0] == 2'b11) mdl[a] = {24'h0, d[7:0]};
      uart_aux_pkg::OFS_PIN_CTRL: begin
        if (d[3]) foreach (mdl[k]) mdl[k] = 32'h0;
        else mdl[a] = {29'h0, d[2:0]};
      end
      uart_aux_pkg::OFS_CORE_CTRL: mdl[a] = {22'h0, d[9:0]};
      uart_aux_pkg::OFS_SCRATCH, uart_aux_pkg::OFS_PIN_DIR, uart_aux_pkg::OFS_PIN_IRQEN:
        mdl[a] = {24'h0, d[7:0]};
      default: ;
    endcase
  endtask
  function automatic logic [31:0] lvl(input logic [3:0] n, input logic [5:0] fb);
    return (n != 4'h0) ? {26'h0, n, 2'b00} : {26'h0, fb};
  endfunction
  task automatic levels();
    logic [7:0] f, t;
    logic [9:0] c;
    repeat (2) @(posedge clk);
    #1;
    f = mdl[uart_aux_pkg::OFS_FLOW][7:0];
    t = mdl[uart_aux_pkg::OFS_TRIGGER][7:0];
    c = mdl[uart_aux_pkg::OFS_CORE_CTRL][9:0];
    chk("halt", f == 8'h00 ? lvl(4'h0, uart_aux_pkg::FCR_RX_LEVELS[c[7:6]])
                           : lvl(f[3:0], 6'h00), {26'h0, fh});
    chk("resume", f == 8'h00 ? {26'h0, uart_aux_pkg::FLOW_RESUME_FB}
                             : lvl(f[7:4], 6'h00), {26'h0, fr});
    chk("rx_trig", lvl(t[7:4], uart_aux_pkg::FCR_RX_LEVELS[c[7:6]]),
        {26'h0, rxl});
    chk("tx_trig", lvl(t[3:0], uart_aux_pkg::FCR_TX_LEVELS[c[9:8]]),
        {26'h0, txl});
  endtask
  task automatic pin(input logic [7:0] v, input logic q);
    @(posedge clk);
    ext <= v;
    repeat (5) @(posedge clk);
    #1;
    chk("gpio_irq", {31'h0, q}, {31'h0, irq});
  endtask
  initial begin
    logic [31:0] d, t, f;
    int v, n;
    void'($urandom(32'h0bc40674));
    for (int i = 0; i < 11; i++) mdl[8'(4 * i)] = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (mdl[k]) rd(k);
    rd(8'h2c);
    d = $urandom;
    wr(uart_aux_pkg::OFS_SCRATCH, d);
    rd(uart_aux_pkg::OFS_SCRATCH);
    wr(uart_aux_pkg::OFS_CORE_CTRL, 32'h1);
    wr(uart_aux_pkg::OFS_FLOW, $urandom);
    wr(uart_aux_pkg::OFS_TRIGGER, $urandom);
    rd(uart_aux_pkg::OFS_FLOW);
    rd(uart_aux_pkg::OFS_TRIGGER);
    for (int i = 0; i < 4; i++) begin
      wr(uart_aux_pkg::OFS_CORE_CTRL, {22'h0, i[1:0], (i[1] ? i[1:0] : 2'b00), 6'h03});
      t = $urandom;
      f = $urandom;
      if (i[0]) t[3:0] = 4'h0;
      if (i[1]) t[7:4] = 4'h0;
      f[3:0] = f[3:0] | 4'h8;
      f[7:4] = f[7:4] & 4'h7;
      if (i == 2) f[7:0] = 8'h00;
      wr(uart_aux_pkg::OFS_FLOW, f);
      wr(uart_aux_pkg::OFS_TRIGGER, t);
      rd(uart_aux_pkg::OFS_FLOW);
      rd(uart_aux_pkg::OFS_TRIGGER);
      levels();
    end
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 64 : $urandom_range(63, 0);
      @(posedge clk);
      tx <= 7'(v);
      rx <= 7'(64 - v);
      mdl[uart_aux_pkg::OFS_TX_SPACE] = 32'(v);
      mdl[uart_aux_pkg::OFS_RX_FILL] = 32'(64 - v);
      rd(uart_aux_pkg::OFS_TX_SPACE);
      rd(uart_aux_pkg::OFS_RX_FILL);
    end
    d = $urandom;
    t = $urandom;
    wr(uart_aux_pkg::OFS_PIN_DIR, d);
    wr(uart_aux_pkg::OFS_PIN_LEVEL, t);
    repeat (4) @(posedge clk);
    #1;
    chk("gpio_oe", {24'h0, d[7:0]}, {24'h0, oe});
    chk("gpio_out", {24'h0, d[7:0] & t[7:0]}, {24'h0, oe & out});
    mdl[uart_aux_pkg::OFS_PIN_LEVEL] = {24'h0, d[7:0] & t[7:0]};
    rd(uart_aux_pkg::OFS_PIN_LEVEL);
    wr(uart_aux_pkg::OFS_PIN_DIR, 32'h0);
    repeat (4) @(posedge clk);
    mdl[uart_aux_pkg::OFS_PIN_LEVEL] = 32'h0;
    rd(uart_aux_pkg::OFS_PIN_LEVEL);
    wr(uart_aux_pkg::OFS_PIN_IRQEN, 32'h1);
    pin(8'h01, 1'b1);
    mdl[uart_aux_pkg::OFS_PIN_LEVEL] = 32'h1;
    rd(uart_aux_pkg::OFS_PIN_LEVEL);
    pin(8'h01, 1'b0);
    pin(8'h03, 1'b0);
    pin(8'h02, 1'b1);
    pin(8'h03, 1'b0);
    mdl[uart_aux_pkg::OFS_PIN_LEVEL] = 32'h3;
    rd(uart_aux_pkg::OFS_PIN_LEVEL);
    wr(uart_aux_pkg::OFS_PIN_CTRL, 32'hf1);
    rd(uart_aux_pkg::OFS_PIN_CTRL);
    pin(8'h02, 1'b1);
    pin(8'h03, 1'b1);
    mdl[uart_aux_pkg::OFS_PIN_LEVEL] = 32'h2;
    rd(uart_aux_pkg::OFS_PIN_LEVEL);
    // Channel A modem duty: pins 7:4 held low read as active status lines.
    wr(uart_aux_pkg::OFS_CORE_CTRL, 32'h3c);
    wr(uart_aux_pkg::OFS_PIN_CTRL, 32'h2);
    pin(8'h03, 1'b0);
    chk("modem_irq", 32'h2, {30'h0, mirq});
    chk("gpio_oe", 32'h20, {24'h0, oe});
    chk("dtr_pin", 32'h0, {31'h0, out[5]});
    mdl[uart_aux_pkg::OFS_MODEM_ST] = 32'hf0;
    rd(uart_aux_pkg::OFS_MODEM_ST);
    pin(8'h13, 1'b0);
    chk("modem_irq", 32'h2, {30'h0, mirq});
    mdl[uart_aux_pkg::OFS_MODEM_ST] = 32'he0;
    rd(uart_aux_pkg::OFS_MODEM_ST);
    mdl[uart_aux_pkg::OFS_PIN_LEVEL] = 32'h3;
    rd(uart_aux_pkg::OFS_PIN_LEVEL);
    wr(uart_aux_pkg::OFS_CORE_CTRL, 32'h34);
    repeat (3) @(posedge clk);
    #1;
    chk("dtr_pin", 32'h1, {31'h0, out[5]});
    chk("modem_irq", 32'h0, {30'h0, mirq});
    wr(uart_aux_pkg::OFS_PIN_CTRL, 32'h8);
    n = 0;
    repeat (3) begin
      #1;
      n += int'(srst);
      @(posedge clk);
    end
    chk("soft_reset", 32'h1, 32'(n));
    rd(uart_aux_pkg::OFS_SCRATCH);
    rd(uart_aux_pkg::OFS_PIN_CTRL);
    levels();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule
